// *** adcc_ctrl_word.v ***
/*
  Configuration-word decoder of a sigma-delta converter: holds the
  24-bit control word, steers register-select accesses, sequences
  calibrations and raises the data-ready flag. Assumes the conversion
  core on the same clock supplies words and calibration results.
*/
`timescale 1ns/1ps
`include "adcc_regs.vh"

module adcc_ctrl_word
(
  input  wire                     clock,
  input  wire                     sys_rst,
  input  wire                     serial_clock,
  input  wire                     transmit_frame_n,
  input  wire                     receive_frame_n,
  input  wire                     register_select_pin,
  input  wire                     serial_data_in,
  input  wire                     conv_valid,
  input  wire [`ADCC_WORD_W-1:0]  conv_data,
  input  wire                     cal_done,
  input  wire [`ADCC_WORD_W-1:0]  cal_zero_coef,
  input  wire [`ADCC_WORD_W-1:0]  cal_full_coef,
  output reg                      data_ready_n,
  output wire                     serial_data_out,
  output wire                     serial_data_oe_n,
  output reg                      cal_start_reg,
  output wire [2:0]               mode_select,
  output wire [2:0]               gain_code,
  output reg  [7:0]               gain_factor_reg,
  output wire                     channel_select,
  output wire                     power_down_bit,
  output wire                     word_length_bit,
  output wire                     comp_current_bit,
  output wire                     burnout_current_bit,
  output wire                     polarity_select,
  output wire [11:0]              filter_code
);

  reg  [`ADCC_WORD_W-1:0] cfg_reg;            // Configuration word
  reg  [`ADCC_WORD_W-1:0] data_reg;           // Conversion data
  reg  [`ADCC_WORD_W-1:0] zero_coef_reg [0:1]; // Zero scale per channel
  reg  [`ADCC_WORD_W-1:0] full_coef_reg [0:1]; // Full scale per channel
  reg                     cal_busy_reg;       // Calibration under way
  reg  [2:0]              bg_cnt_reg;         // Background word divider
  reg                     rd_data_reg;        // Current read is data
  reg  [`ADCC_WORD_W-1:0] rd_word;            // Word offered to a read
  reg  [`ADCC_CNT_W-1:0]  rd_len;             // Its length in bits
  wire                    sel_level;          // Synced register select
  wire                    wr_pulse;           // Full write frame ended
  wire [`ADCC_WORD_W-1:0] wr_word;            // Received word
  wire                    rd_start;           // Read frame opened
  wire                    rd_done;            // Full word shifted out
  wire [2:0]              mode;               // Current mode bits
  integer                 i;

  // One-shot calibration modes end by themselves
  function is_cal;
    input [2:0] md;
    begin
      is_cal = (md == `ADCC_MD_SELF) || (md == `ADCC_MD_SYSZ) ||
               (md == `ADCC_MD_SYSF) || (md == `ADCC_MD_SYSOFF);
    end
  endfunction

  // Modes that redirect register-select accesses to coefficients
  function is_coef;
    input [2:0] md;
    begin
      is_coef = (md == `ADCC_MD_RWZ) || (md == `ADCC_MD_RWF);
    end
  endfunction

  // Field slices of the word, all straight from cfg_reg
  assign mode                = cfg_reg[`ADCC_MODE_HI:`ADCC_MODE_LO];
  assign mode_select         = mode;
  assign gain_code           = cfg_reg[`ADCC_GAIN_HI:`ADCC_GAIN_LO];
  assign channel_select      = cfg_reg[`ADCC_CHAN_BIT];
  assign power_down_bit      = cfg_reg[`ADCC_PWDN_BIT];
  assign word_length_bit     = cfg_reg[`ADCC_WLEN_BIT];
  assign comp_current_bit    = cfg_reg[`ADCC_IO_BIT];
  assign burnout_current_bit = cfg_reg[`ADCC_BURN_BIT];
  assign polarity_select     = cfg_reg[`ADCC_BU_BIT];
  assign filter_code         = cfg_reg[`ADCC_FS_HI:`ADCC_FS_LO];

  // Serial frames; the port holds the pin-facing flops
  adcc_serial_port u_port
  (
    .clock               (clock),
    .sys_rst             (sys_rst),
    .serial_clock        (serial_clock),
    .transmit_frame_n    (transmit_frame_n),
    .receive_frame_n     (receive_frame_n),
    .register_select_pin (register_select_pin),
    .serial_data_in      (serial_data_in),
    .rd_word             (rd_word),
    .rd_len              (rd_len),
    .sel_level_reg       (sel_level),
    .wr_pulse_reg        (wr_pulse),
    .wr_word_reg         (wr_word),
    .rd_start_reg        (rd_start),
    .rd_done_reg         (rd_done),
    .sdata_out_reg       (serial_data_out),
    .sdata_oe_n_reg      (serial_data_oe_n)
  );

  // Read source and length chosen from select pin and mode
  always @*
  begin
    rd_word = cfg_reg;
    rd_len  = `ADCC_LEN24;
    if (sel_level)
    begin
      if (mode == `ADCC_MD_RWZ)
        rd_word = zero_coef_reg[channel_select];
      else if (mode == `ADCC_MD_RWF)
        rd_word = full_coef_reg[channel_select];
      else
      begin
        // Data word; 16-bit reads take the top 16 bits
        rd_word = data_reg;
        rd_len  = word_length_bit ? `ADCC_LEN24 : `ADCC_LEN16;
      end
    end
  end

  // Word, coefficient, calibration and ready sequencing
  always @(posedge clock)
  begin
    if (sys_rst)
    begin
      // Normal mode, gain one, channel zero, short words
      cfg_reg         <= `ADCC_CFG_RESET;
      data_reg        <= `ADCC_DATA_RESET;
      data_ready_n    <= 1'b1;
      cal_busy_reg    <= 1'b0;
      cal_start_reg   <= 1'b0;
      bg_cnt_reg      <= `ADCC_BG_ZERO;
      rd_data_reg     <= 1'b0;
      gain_factor_reg <= `ADCC_GAIN_ONE;
      for (i = 0; i < 2; i = i + 1)
      begin
        zero_coef_reg[i] <= `ADCC_ZC_RESET;
        full_coef_reg[i] <= `ADCC_FC_RESET;
      end
    end
    else
    begin
      cal_start_reg   <= 1'b0;
      gain_factor_reg <= `ADCC_GAIN_ONE << gain_code;
      if (rd_start)
        rd_data_reg <= sel_level && !is_coef(mode);
      if (wr_pulse)
      begin
        if (!sel_level)
        begin
          // Complete control word; a calibration starts at once
          cfg_reg <= wr_word;
          // A new word abandons a step in progress; a cal mode restarts it
          cal_busy_reg <= 1'b0;
          if (is_cal(wr_word[`ADCC_MODE_HI:`ADCC_MODE_LO]))
          begin
            cal_busy_reg  <= 1'b1;
            cal_start_reg <= 1'b1;
            data_ready_n  <= 1'b1;
          end
          bg_cnt_reg <= `ADCC_BG_ZERO;
        end
        // Data register is read-only; other selected writes drop
        else if (mode == `ADCC_MD_RWZ)
          zero_coef_reg[channel_select] <= wr_word;
        else if (mode == `ADCC_MD_RWF)
          full_coef_reg[channel_select] <= wr_word;
      end
      else if (cal_busy_reg && cal_done)
      begin
        // Store what this step measured, then back to normal
        if (mode != `ADCC_MD_SYSF)
          zero_coef_reg[channel_select] <= cal_zero_coef;
        if (mode != `ADCC_MD_SYSZ)
          full_coef_reg[channel_select] <= cal_full_coef;
        cfg_reg[`ADCC_MODE_HI:`ADCC_MODE_LO] <= `ADCC_MD_NORMAL;
        cal_busy_reg <= 1'b0;
        data_ready_n <= 1'b0;
      end
      else if (!cal_busy_reg)
      begin
        // Background updates both coefficients in place
        if (mode == `ADCC_MD_BG && cal_done)
        begin
          zero_coef_reg[channel_select] <= cal_zero_coef;
          full_coef_reg[channel_select] <= cal_full_coef;
        end
        if (conv_valid)
        begin
          if (mode == `ADCC_MD_BG)
            bg_cnt_reg <= (bg_cnt_reg == `ADCC_BG_LAST) ?
                          `ADCC_BG_ZERO : bg_cnt_reg + 3'h1;
          if (mode != `ADCC_MD_BG || bg_cnt_reg == `ADCC_BG_LAST)
          begin
            // New word wins over a read ending this cycle
            data_reg     <= conv_data;
            data_ready_n <= 1'b0;
          end
          else if (rd_done && rd_data_reg)
            data_ready_n <= 1'b1;
        end
        else if (rd_done && rd_data_reg)
          data_ready_n <= 1'b1;
      end
    end
  end

endmodule // adcc_ctrl_word

// *** adcc_ctrl_word_props.sv ***
/* Port checker for the control-word block.
   Assumes one clock domain and a synchronous active-high reset. */
`timescale 1ns/1ps
module adcc_props
(
  input wire       clock,
  input wire       sys_rst,
  input wire       receive_frame_n,
  input wire       conv_valid,
  input wire       cal_done,
  input wire       data_ready_n,
  input wire       serial_data_oe_n,
  input wire       cal_start_reg,
  input wire [2:0] mode_select,
  input wire [2:0] gain_code,
  input wire [7:0] gain_factor_reg
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  // A one-shot calibration step reports its end
  sequence s_cal_end;
    cal_done && mode_select inside {[3'h1:3'h4]} && !cal_start_reg;
  endsequence
  // Back in normal mode with the finish flagged
  sequence s_back_normal;
    mode_select == 3'h0 && !data_ready_n;
  endsequence
  property p_gain;
    1'b1 |=> gain_factor_reg == (8'h01 << $past(gain_code));
  endproperty
  a_gain: assert property (p_gain)
    else $error("gain factor wrong");
  property p_cal_done;
    s_cal_end |-> ##1 s_back_normal;
  endproperty
  a_cal_done: assert property (p_cal_done)
    else $error("calibration end not seen");
  property p_start_once;
    cal_start_reg |=> !cal_start_reg;
  endproperty
  a_start_once: assert property (p_start_once)
    else $error("start pulse too long");
  property p_start_mode;
    cal_start_reg |-> mode_select inside {[3'h1:3'h4]} && data_ready_n;
  endproperty
  a_start_mode: assert property (p_start_mode)
    else $error("start pulse outside calibration");
  property p_start_cause;
    $changed(mode_select) && mode_select inside {[3'h1:3'h4]}
      |-> cal_start_reg;
  endproperty
  a_start_cause: assert property (p_start_cause)
    else $error("calibration not started");
  property p_busy;
    mode_select inside {[3'h1:3'h4]} |-> data_ready_n;
  endproperty
  a_busy: assert property (p_busy)
    else $error("ready flag low while calibrating");
  property p_take;
    conv_valid && mode_select == 3'h0 |-> ##[1:2] !data_ready_n;
  endproperty
  a_take: assert property (p_take)
    else $error("new word not flagged");
  property p_oe_idle;
    receive_frame_n [*8] |-> serial_data_oe_n;
  endproperty
  a_oe_idle: assert property (p_oe_idle)
    else $error("data line driven outside read");
  property p_bg_stay;
    mode_select == 3'h5 && cal_done |=> mode_select == 3'h5;
  endproperty
  a_bg_stay: assert property (p_bg_stay)
    else $error("background mode left");
endmodule // adcc_props

bind adcc_ctrl_word adcc_props u_props
(
  .clock(clock), .sys_rst(sys_rst), .receive_frame_n(receive_frame_n),
  .conv_valid(conv_valid), .cal_done(cal_done),
  .data_ready_n(data_ready_n), .serial_data_oe_n(serial_data_oe_n),
  .cal_start_reg(cal_start_reg), .mode_select(mode_select),
  .gain_code(gain_code), .gain_factor_reg(gain_factor_reg)
);

// *** adcc_ctrl_word_tb_top.sv ***
/* Self-checking bench of the control-word block.
   Assumes the design files and the host model compile first. */
`timescale 1ns/1ps
`include "adcc_regs.vh"
module adcc_ctrl_word_tb_top;
  logic        clock = 1'b0;      // 25 MHz system clock
  logic        sys_rst = 1'b1;    // Synchronous reset
  logic        conv_valid = 1'b0; // Core word strobe
  logic        cal_done = 1'b0;   // Core calibration strobe
  logic [23:0] conv_data = 24'h0, cal_zero_coef = 24'h0;
  logic [23:0] cal_full_coef = 24'h0;
  logic [23:0] lfsr = 24'h000011; // Random source, seed 17
  logic [23:0] cfg_m, zc_m[2], fc_m[2], r; // Expected contents
  logic [23:0] exp_q[$];          // Expected read words, oldest first
  logic        chan;              // Channel under test
  int          error_cnt = 0;
  int          n_compared = 0;
  wire         sclk, wframe_n, rframe_n, sel, host_bit, ready_n, sdo, oe_n;
  wire         cal_start, pwdn, wlen, io, burn, bu, chan_sel;
  wire [2:0]   mode_select, gain_code;
  wire [7:0]   gain_factor_reg;
  wire [11:0]  filter_code;
  wire [23:0]  cfg_seen = {mode_select, gain_code, chan_sel, pwdn, wlen,
                           io, burn, bu, filter_code};
  // Shared data wire: device wins while enabled
  wire         sdata_line = oe_n ? host_bit : sdo;
  always #20 clock = ~clock;
  adcc_ctrl_word u_dut
  (
    .clock(clock), .sys_rst(sys_rst), .serial_clock(sclk),
    .transmit_frame_n(wframe_n), .receive_frame_n(rframe_n),
    .register_select_pin(sel), .serial_data_in(sdata_line),
    .conv_valid(conv_valid), .conv_data(conv_data), .cal_done(cal_done),
    .cal_zero_coef(cal_zero_coef), .cal_full_coef(cal_full_coef),
    .data_ready_n(ready_n), .serial_data_out(sdo),
    .serial_data_oe_n(oe_n), .cal_start_reg(cal_start),
    .mode_select(mode_select), .gain_code(gain_code),
    .gain_factor_reg(gain_factor_reg), .channel_select(chan_sel),
    .power_down_bit(pwdn), .word_length_bit(wlen), .comp_current_bit(io),
    .burnout_current_bit(burn), .polarity_select(bu),
    .filter_code(filter_code)
  );
  adcc_host_model u_host
  (
    .clock(clock), .sdata_line(sdata_line), .serial_clock(sclk),
    .transmit_frame_n(wframe_n), .receive_frame_n(rframe_n),
    .register_select_pin(sel), .host_bit(host_bit)
  );
  // Pseudo-random words
  function automatic logic [23:0] rnd();
    lfsr = {lfsr[22:0], lfsr[23] ^ lfsr[22] ^ lfsr[21] ^ lfsr[16]};
    return lfsr;
  endfunction
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("ERROR %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  // Control-word frame; short frames leave the model unchanged
  task automatic wr_cfg(input logic [31:0] w, input int n);
    u_host.send(1'b0, w, n);
    if (n >= 24)
      cfg_m = w[31:8];
    check(cfg_seen, cfg_m);
  endtask
  task automatic rd(input logic s, input int n, input logic [23:0] e);
    exp_q.push_back(e);
    u_host.fetch(s, n);
  endtask
  // One core strobe with fresh random payloads
  task automatic pulse(input logic cv, input logic cd);
    conv_data = rnd();
    cal_zero_coef = rnd();
    cal_full_coef = rnd();
    conv_valid = cv;
    cal_done = cd;
    @(negedge clock);
    conv_valid = 1'b0;
    cal_done = 1'b0;
    @(negedge clock);
  endtask
  // Pairs each fetched word with the oldest expectation
  always @(u_host.rd_done)
    check(u_host.rd_word, exp_q.pop_front());
  task automatic end_of_test();
    $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Watchdog well beyond the expected run of some 10,000 cycles
  initial
  begin
    #2000000;
    error_cnt++;
    end_of_test();
  end
  // Main sequence
  initial
  begin
    repeat (3) @(negedge clock);
    sys_rst = 1'b0;
    repeat (4) @(negedge clock);
    zc_m = '{`ADCC_ZC_RESET, `ADCC_ZC_RESET};
    fc_m = '{`ADCC_FC_RESET, `ADCC_FC_RESET};
    check(ready_n, 1'b1);
    check(gain_factor_reg, `ADCC_GAIN_ONE);
    check({mode_select, chan_sel, wlen}, 5'h00);
    cfg_m = `ADCC_CFG_RESET;
    rd(1'b0, 24, cfg_m);
    $display("Test reset done");
    for (int g = 0; g < 8; g++)
    begin
      r = rnd();
      wr_cfg({3'h0, 3'(g), r[17:12], 12'h013 + {2'h0, r[9:0]}, 8'h00}, 24);
      check(gain_factor_reg, 8'h01 << g);
    end
    rd(1'b0, 24, cfg_m);
    wr_cfg(32'hFFFFFFFF, 20);
    wr_cfg({24'h0080C8, 8'hA5}, 28);
    $display("Test control word done");
    pulse(1'b1, 1'b0);
    check(ready_n, 1'b0);
    rd(1'b1, 24, conv_data);
    check(ready_n, 1'b1);
    wr_cfg({24'hA000C8, 8'h00}, 24);
    for (int i = 1; i <= 6; i++)
    begin
      pulse(1'b1, 1'b0);
      check(ready_n, 1'(i < 6));
    end
    rd(1'b1, 16, {8'h00, conv_data[23:8]});
    pulse(1'b0, 1'b1);
    check(mode_select, 3'h5);
    zc_m[0] = cal_zero_coef;
    fc_m[0] = cal_full_coef;
    $display("Test data and background done");
    for (int m = 1; m <= 4; m++)
    begin
      r = rnd();
      chan = r[0];
      wr_cfg({3'(m), 3'h0, chan, 17'h000C8, 8'h00}, 24);
      pulse(1'b1, 1'b0);
      check(ready_n, 1'b1);
      pulse(1'b0, 1'b1);
      check({mode_select, ready_n}, 4'h0);
      if (m != 3)
        zc_m[chan] = cal_zero_coef;
      if (m != 2)
        fc_m[chan] = cal_full_coef;
      wr_cfg({3'h6, 3'h0, chan, 17'h000C8, 8'h00}, 24);
      rd(1'b1, 24, zc_m[chan]);
      wr_cfg({3'h7, 3'h0, chan, 17'h000C8, 8'h00}, 24);
      rd(1'b1, 24, fc_m[chan]);
    end
    $display("Test calibration done");
    // Both coefficient kinds: full words land, short ones are dropped
    for (int k = 6; k <= 7; k++)
    begin
      wr_cfg({3'(k), 3'h0, chan, 17'h000C8, 8'h00}, 24);
      r = rnd();
      u_host.send(1'b1, {r, 8'h00}, 24);
      rd(1'b1, 24, r);
      u_host.send(1'b1, {rnd(), 8'h00}, 16);
      rd(1'b1, 24, r);
    end
    $display("Test coefficient write done");
    // Let the watcher take the last read before the verdict
    @(negedge clock);
    end_of_test();
  end
endmodule // adcc_ctrl_word_tb_top

// *** adcc_host_model.sv ***
/* Host side of the serial link: writes and reads whole frames.
   Assumes a 320 ns link clock built from eight system clocks. */
`timescale 1ns/1ps
module adcc_host_model
(
  input  wire  clock,
  input  wire  sdata_line,
  output logic serial_clock,
  output logic transmit_frame_n,
  output logic receive_frame_n,
  output logic register_select_pin,
  output logic host_bit
);
  logic [23:0] rd_word; // Last word fetched
  event        rd_done; // Raised after each read frame
  // Idle link: clock and frames high
  initial
  begin
    {serial_clock, transmit_frame_n, receive_frame_n} = 3'h7;
    register_select_pin = 1'b0;
    host_bit = 1'b0;
  end
  // Pins move on falling system edges only
  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask
  // Sends the top n bits of w, MSB first
  task automatic send(input logic sel, input logic [31:0] w, input int n);
    register_select_pin = sel;
    tick(4);
    transmit_frame_n = 1'b0;
    tick(4);
    for (int i = 0; i < n; i++)
    begin
      host_bit = w[31-i];
      serial_clock = 1'b0;
      tick(4);
      serial_clock = 1'b1;
      tick(4);
    end
    transmit_frame_n = 1'b1;
    host_bit = ~host_bit; // Released line must not show a stale bit
    tick(12);
  endtask
  // Sample late in the high phase, the bit moves after the fall
  task automatic fetch(input logic sel, input int n);
    register_select_pin = sel;
    tick(4);
    receive_frame_n = 1'b0;
    rd_word = 24'h000000;
    tick(8);
    for (int i = 0; i < n; i++)
    begin
      serial_clock = 1'b0;
      tick(4);
      serial_clock = 1'b1;
      tick(4);
      rd_word = {rd_word[22:0], sdata_line};
    end
    tick(8);
    receive_frame_n = 1'b1;
    tick(8);
    -> rd_done;
  endtask
endmodule // adcc_host_model

// *** adcc_regs.vh ***
/*
  Constants of the converter control-word block: field positions of the
  24-bit configuration word, mode codes, reset values and serial counts.
  Assumes it is included once by each design file that needs it.
*/
`ifndef ADCC_REGS_VH
`define ADCC_REGS_VH

// Word and bit-counter widths
`define ADCC_WORD_W     24
`define ADCC_CNT_W      5
// Configuration word fields, MSB first
`define ADCC_MODE_HI    23
`define ADCC_MODE_LO    21
`define ADCC_GAIN_HI    20
`define ADCC_GAIN_LO    18
`define ADCC_CHAN_BIT   17
`define ADCC_PWDN_BIT   16
`define ADCC_WLEN_BIT   15
`define ADCC_IO_BIT     14
`define ADCC_BURN_BIT   13
`define ADCC_BU_BIT     12
`define ADCC_FS_HI      11
`define ADCC_FS_LO      0
// Operating modes
`define ADCC_MD_NORMAL  3'h0
`define ADCC_MD_SELF    3'h1
`define ADCC_MD_SYSZ    3'h2
`define ADCC_MD_SYSF    3'h3
`define ADCC_MD_SYSOFF  3'h4
`define ADCC_MD_BG      3'h5
`define ADCC_MD_RWZ     3'h6
`define ADCC_MD_RWF     3'h7
// Reset values; filter default keeps the code inside its legal range
`define ADCC_CFG_RESET  24'h0000C8
`define ADCC_ZC_RESET   24'h000000
`define ADCC_FC_RESET   24'h800000
`define ADCC_DATA_RESET 24'h000000
`define ADCC_GAIN_ONE   8'h01
// Serial word lengths in bits
`define ADCC_LEN16      5'h10
`define ADCC_LEN24      5'h18
// Background mode passes one conversion in six
`define ADCC_BG_LAST    3'h5
`define ADCC_BG_ZERO    3'h0

`endif

// *** adcc_serial_port.v ***
/*
  Serial port of the control-word block: synchronises the link pins,
  shifts write frames in and read frames out, reports complete frames.
  Assumes the host drives the link clock, idle high; data in on rising
  edges, data out changes on falling edges.
*/
`timescale 1ns/1ps
`include "adcc_regs.vh"

module adcc_serial_port
(
  input  wire                     clock,
  input  wire                     sys_rst,
  input  wire                     serial_clock,
  input  wire                     transmit_frame_n,
  input  wire                     receive_frame_n,
  input  wire                     register_select_pin,
  input  wire                     serial_data_in,
  input  wire [`ADCC_WORD_W-1:0]  rd_word,
  input  wire [`ADCC_CNT_W-1:0]   rd_len,
  output reg                      sel_level_reg,
  output reg                      wr_pulse_reg,
  output reg  [`ADCC_WORD_W-1:0]  wr_word_reg,
  output reg                      rd_start_reg,
  output reg                      rd_done_reg,
  output reg                      sdata_out_reg,
  output reg                      sdata_oe_n_reg
);

  // Three-stage synchronisers for the five pins
  reg [4:0] s1_reg;
  reg [4:0] s2_reg;
  reg [4:0] s3_reg;
  reg [4:0] lvl_reg;                    // Filtered pin levels
  wire [4:0] pins;
  wire [4:0] lvl_next;
  reg [`ADCC_CNT_W-1:0]  wr_cnt_reg;    // Bits received this frame
  reg [`ADCC_CNT_W-1:0]  rd_cnt_reg;    // Bits sent this frame
  reg [`ADCC_WORD_W-1:0] rd_shift_reg;  // Outgoing word
  reg [`ADCC_CNT_W-1:0]  rd_len_reg;    // Length latched at frame start

  assign pins = {serial_data_in, register_select_pin, receive_frame_n,
                 transmit_frame_n, serial_clock};
  // A change counts once stages two and three agree
  assign lvl_next = (s2_reg & s3_reg) | (lvl_reg & (s2_reg | s3_reg));

  wire sclk_rise = lvl_next[0] & ~lvl_reg[0];
  wire sclk_fall = ~lvl_next[0] & lvl_reg[0];
  wire wframe_rise = lvl_next[1] & ~lvl_reg[1];
  wire rframe_fall = ~lvl_next[2] & lvl_reg[2];
  wire rframe_rise = lvl_next[2] & ~lvl_reg[2];

  // Synchroniser chain; stage one feeds only stage two
  always @(posedge clock)
  begin
    if (sys_rst)
    begin
      s1_reg  <= 5'h07;
      s2_reg  <= 5'h07;
      s3_reg  <= 5'h07;
      lvl_reg <= 5'h07;
    end
    else
    begin
      s1_reg  <= pins;
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      lvl_reg <= lvl_next;
    end
  end

  // Write frames: shift in while transmit frame is low
  always @(posedge clock)
  begin
    if (sys_rst)
    begin
      wr_cnt_reg   <= {`ADCC_CNT_W{1'b0}};
      wr_word_reg  <= {`ADCC_WORD_W{1'b0}};
      wr_pulse_reg <= 1'b0;
    end
    else
    begin
      wr_pulse_reg <= 1'b0;
      if (wframe_rise)
      begin
        // Short frames are dropped, never loaded
        wr_pulse_reg <= (wr_cnt_reg == `ADCC_LEN24);
        wr_cnt_reg   <= {`ADCC_CNT_W{1'b0}};
      end
      else if (!lvl_reg[1] && sclk_rise && wr_cnt_reg != `ADCC_LEN24)
      begin
        // Edges past the 24th are ignored
        wr_word_reg <= {wr_word_reg[`ADCC_WORD_W-2:0], lvl_next[4]};
        wr_cnt_reg  <= wr_cnt_reg + 5'h01;
      end
    end
  end

  // Read frames: drive the line while receive frame is low
  always @(posedge clock)
  begin
    if (sys_rst)
    begin
      rd_cnt_reg     <= {`ADCC_CNT_W{1'b0}};
      rd_shift_reg   <= {`ADCC_WORD_W{1'b0}};
      rd_len_reg     <= `ADCC_LEN24;
      rd_start_reg   <= 1'b0;
      rd_done_reg    <= 1'b0;
      sdata_out_reg  <= 1'b0;
      sdata_oe_n_reg <= 1'b1;
      sel_level_reg  <= 1'b0;
    end
    else
    begin
      sel_level_reg <= lvl_next[3];
      rd_start_reg  <= rframe_fall;
      rd_done_reg   <= 1'b0;
      if (rframe_fall)
      begin
        // MSB first, presented as soon as the frame opens
        rd_shift_reg   <= rd_word;
        rd_len_reg     <= rd_len;
        rd_cnt_reg     <= {`ADCC_CNT_W{1'b0}};
        sdata_out_reg  <= rd_word[`ADCC_WORD_W-1];
        sdata_oe_n_reg <= 1'b0;
      end
      else if (rframe_rise)
        sdata_oe_n_reg <= 1'b1;
      else if (!lvl_reg[2])
      begin
        if (sclk_rise && rd_cnt_reg != rd_len_reg)
        begin
          rd_cnt_reg  <= rd_cnt_reg + 5'h01;
          rd_done_reg <= (rd_cnt_reg + 5'h01 == rd_len_reg);
        end
        else if (sclk_fall && rd_cnt_reg != 5'h00)
        begin
          // Next bit after the host sampled the last one
          rd_shift_reg  <= {rd_shift_reg[`ADCC_WORD_W-2:0], 1'b0};
          sdata_out_reg <= rd_shift_reg[`ADCC_WORD_W-2];
        end
      end
    end
  end

endmodule // adcc_serial_port
